// *** design/lsb_core.v ***
// Purpose: serial transmitter with break and idle generation, receiver with LIN slave header timing
// Assumes: baud_div_i gives system clocks per oversampling tick, nonzero
// Notes: clk_en_i low freezes every register
`include "lsb_consts.vh"
module lsb_core (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        clk_en_i,
  input  wire [15:0] baud_div_i,
  input  wire        transmitter_enable_bit_i,
  input  wire        send_break_bit_i,
  input  wire        word_len_bit_i,
  input  wire        lin_enable_bit_i,
  input  wire        lin_slave_bit_i,
  input  wire [7:0]  tx_data_i,
  input  wire        tx_load_i,
  input  wire        mute_set_i,
  input  wire        status_rd_i,
  input  wire        data_rd_i,
  input  wire        rx_pin_i,
  output wire        tx_pin_o,
  output wire        tx_ready_o,
  output wire        lin_master_o,
  output wire        mute_o,
  output wire        receive_full_flag_o,
  output wire        header_detected_flag_o,
  output wire        header_error_flag_o,
  output wire [7:0]  serial_data_register_o,
  output wire        irq_o
);
  localparam [15:0] ONE16 = 16'h0001;

  // break length for the current mode
  function [3:0] brk_len;
    input lin_m;
    input m9;
    begin
      if (lin_m)
        brk_len = `LSB_BRK_BITS_LIN;
      else if (m9)
        brk_len = `LSB_BRK_BITS_9;
      else
        brk_len = `LSB_BRK_BITS_8;
    end
  endfunction

  reg [15:0] div_q;
  reg        os_tick_q;
  reg [2:0]  rx_sync_q;
  reg        rx_line_q;
  reg        tx_en_prev_q;
  reg        brk_bit_prev_q;
  reg        idle_pend_q;
  reg        brk_pend_q;
  reg [1:0]  tx_st_q;
  reg [3:0]  tx_os_q;
  reg [3:0]  tx_bits_q;
  reg [10:0] tx_sh_q;
  reg        tx_pin_q;
  reg        rx_busy_q;
  reg [3:0]  rx_os_q;
  reg [3:0]  rx_idx_q;
  reg [8:0]  rx_sh_q;
  reg [7:0]  rx_data_q;
  reg        rx_full_q;
  reg        hdr_found_q;
  reg        hdr_err_q;
  reg        mute_q;
  reg        stat_seen_q;
  reg [7:0]  low_cnt_q;
  reg [1:0]  hdr_st_q;
  reg [9:0]  hdr_os_q;
  reg        byte_done;
  reg        byte_ok;
  wire       lin_master;
  wire       hdr_timeout;
  wire       ident_done;
  wire       rx_sample;
  wire [3:0] rx_last;

  assign lin_master = lin_enable_bit_i & ~word_len_bit_i;
  assign rx_last    = word_len_bit_i ? `LSB_DATA_BITS_9 - 4'h1 : `LSB_DATA_BITS_8 - 4'h1;
  assign rx_sample  = os_tick_q & rx_busy_q & (rx_os_q == `LSB_OS_MID);
  assign hdr_timeout = (hdr_st_q != `LSB_HDR_NONE) & (hdr_os_q > {`LSB_HDR_MAX_BITS, 4'h0}); // ticks past 57 bits
  assign ident_done = byte_done & byte_ok & (hdr_st_q == `LSB_HDR_IDENT) & ~hdr_timeout;

  // oversampling tick divider, sixteen ticks per bit
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_q     <= 16'h0000;
      os_tick_q <= 1'b0;
    end else if (clk_en_i) begin
      if (div_q + ONE16 >= baud_div_i) begin
        div_q     <= 16'h0000;
        os_tick_q <= 1'b1;
      end else begin
        div_q     <= div_q + ONE16;
        os_tick_q <= 1'b0;
      end
    end
  end

  // three-stage input synchroniser, level changes when stages two and three agree
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_sync_q <= 3'h7;
      rx_line_q <= 1'b1;
    end else if (clk_en_i) begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin_i};
      if (rx_sync_q[1] == rx_sync_q[2])
        rx_line_q <= rx_sync_q[2];
    end
  end

  // transmit request capture and frame sequencer
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_en_prev_q   <= 1'b0;
      brk_bit_prev_q <= 1'b0;
      idle_pend_q <= 1'b0;
      brk_pend_q  <= 1'b0;
      tx_st_q     <= `LSB_TX_IDLE;
      tx_os_q     <= 4'h0;
      tx_bits_q   <= 4'h0;
      tx_sh_q     <= 11'h7ff;
      tx_pin_q    <= 1'b1;
    end else if (clk_en_i) begin
      tx_en_prev_q   <= transmitter_enable_bit_i;
      brk_bit_prev_q <= send_break_bit_i;
      if (transmitter_enable_bit_i & ~tx_en_prev_q)
        idle_pend_q <= 1'b1;
      if (send_break_bit_i & ~brk_bit_prev_q)
        brk_pend_q <= 1'b1;
      case (tx_st_q)
        `LSB_TX_IDLE: begin
          tx_pin_q <= 1'b1;
          tx_os_q  <= 4'h0;
          if (!transmitter_enable_bit_i) begin
            tx_st_q <= `LSB_TX_IDLE;
          end else if (idle_pend_q || !tx_en_prev_q) begin
            idle_pend_q <= 1'b0; // idle goes out ahead of a pending break or load
            tx_bits_q   <= word_len_bit_i ? `LSB_IDLE_BITS_9 : `LSB_IDLE_BITS_8;
            tx_st_q     <= `LSB_TX_IDLECHR;
          end else if (brk_pend_q | send_break_bit_i) begin
            brk_pend_q <= 1'b0;
            tx_bits_q  <= brk_len(lin_master, word_len_bit_i);
            tx_pin_q   <= 1'b0;
            tx_st_q    <= `LSB_TX_BREAK;
          end else if (tx_load_i) begin
            tx_sh_q   <= {1'b1, 1'b1, tx_data_i, 1'b0};
            tx_bits_q <= word_len_bit_i ? `LSB_DATA_BITS_9 : `LSB_DATA_BITS_8;
            tx_pin_q  <= 1'b0;
            tx_st_q   <= `LSB_TX_DATA;
          end
        end
        default: begin
          if (os_tick_q) begin
            tx_os_q <= tx_os_q + 4'h1;
            if (tx_os_q == 4'hf) begin
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_st_q == `LSB_TX_DATA) begin
                tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                tx_pin_q <= tx_sh_q[1];
              end
              if (tx_bits_q == 4'h1) begin
                // a break ends once; a new one starts only if the bit is still set
                if ((tx_st_q == `LSB_TX_BREAK) && send_break_bit_i && !idle_pend_q) begin
                  brk_pend_q <= 1'b0;
                  tx_bits_q  <= brk_len(lin_master, word_len_bit_i);
                  tx_pin_q   <= 1'b0;
                end else begin
                  tx_pin_q <= 1'b1;
                  tx_st_q  <= `LSB_TX_IDLE;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // receive byte engine, one sample per bit at tick 8 of sixteen
  always @* begin
    byte_done = rx_sample & (rx_idx_q == rx_last);
    byte_ok   = rx_line_q;
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_busy_q <= 1'b0;
      rx_os_q   <= 4'h0;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
    end else if (clk_en_i) begin
      if (!rx_busy_q) begin
        rx_os_q  <= 4'h0;
        rx_idx_q <= 4'h0;
        if (!rx_line_q && (low_cnt_q == 8'h00))
          rx_busy_q <= 1'b1;
      end else if (os_tick_q) begin
        rx_os_q <= rx_os_q + 4'h1;
        if (rx_sample) begin
          rx_sh_q <= {rx_line_q, rx_sh_q[8:1]};
          if (((rx_idx_q == 4'h0) && rx_line_q) || byte_done)
            rx_busy_q <= 1'b0;
        end
        if (rx_os_q == 4'hf)
          rx_idx_q <= rx_idx_q + 4'h1;
      end
    end
  end

  // break detector, header timer and status flags
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      low_cnt_q   <= 8'h00;
      hdr_st_q    <= `LSB_HDR_NONE;
      hdr_os_q    <= 10'h000;
      rx_data_q   <= 8'h00;
      rx_full_q   <= 1'b0;
      hdr_found_q <= 1'b0;
      hdr_err_q   <= 1'b0;
      mute_q      <= 1'b0;
      stat_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      if (rx_line_q)
        low_cnt_q <= 8'h00;
      else if (os_tick_q && (low_cnt_q != 8'hff))
        low_cnt_q <= low_cnt_q + 8'h01;
      // saturates at full scale so the timeout compare can still be reached
      if ((hdr_st_q != `LSB_HDR_NONE) && os_tick_q && (hdr_os_q != 10'h3ff))
        hdr_os_q <= hdr_os_q + 10'h001;
      // header sequence in slave mode
      if (!lin_slave_bit_i || !lin_enable_bit_i) begin
        hdr_st_q <= `LSB_HDR_NONE;
      end else if (hdr_timeout) begin
        hdr_st_q <= `LSB_HDR_NONE; // abort, no wake and no detect
      end else if (os_tick_q && (low_cnt_q == `LSB_RX_BRK_BITS - 8'h01)) begin
        hdr_st_q <= `LSB_HDR_BREAK;
        hdr_os_q <= {2'b00, `LSB_RX_BRK_BITS};
      end else if ((hdr_st_q == `LSB_HDR_BREAK) && rx_busy_q && (low_cnt_q == 8'h00)) begin
        hdr_st_q <= `LSB_HDR_SYNC;
      end else if ((hdr_st_q == `LSB_HDR_SYNC) && byte_done) begin
        hdr_st_q <= `LSB_HDR_IDENT;
      end else if (ident_done) begin
        hdr_st_q <= `LSB_HDR_NONE;
      end
      if (byte_done && byte_ok) begin
        rx_data_q <= word_len_bit_i ? rx_sh_q[7:0] : rx_sh_q[8:1]; // ninth bit dropped
      end
      // clear sequence: status read while a flag stands, then data read
      if (status_rd_i && (hdr_err_q || rx_full_q || hdr_found_q))
        stat_seen_q <= 1'b1;
      else if (data_rd_i)
        stat_seen_q <= 1'b0;
      if (stat_seen_q && data_rd_i) begin
        hdr_err_q   <= 1'b0;
        rx_full_q   <= 1'b0;
        hdr_found_q <= 1'b0;
      end
      // set terms come last so a same-cycle event wins over the clear
      if (mute_set_i)
        mute_q <= 1'b1;
      if (hdr_timeout)
        hdr_err_q <= 1'b1;
      if (ident_done) begin
        hdr_found_q <= 1'b1;
        rx_full_q   <= 1'b1;
        mute_q      <= 1'b0;
      end else if (byte_done && byte_ok && !mute_q && (hdr_st_q == `LSB_HDR_NONE)) begin
        rx_full_q <= 1'b1;
      end else if (byte_done && byte_ok && !mute_q && (hdr_st_q == `LSB_HDR_SYNC)) begin
        rx_full_q <= 1'b1;
      end
    end
  end

  assign tx_pin_o               = tx_pin_q;
  assign tx_ready_o             = (tx_st_q == `LSB_TX_IDLE) & transmitter_enable_bit_i & tx_en_prev_q &
                                  ~idle_pend_q & ~brk_pend_q & ~send_break_bit_i;
  assign lin_master_o           = lin_master;
  assign mute_o                 = mute_q;
  assign receive_full_flag_o    = rx_full_q;
  assign header_detected_flag_o = hdr_found_q;
  assign header_error_flag_o    = hdr_err_q;
  assign serial_data_register_o = rx_data_q;
  assign irq_o                  = hdr_err_q | hdr_found_q | rx_full_q;
endmodule

// *** design/lsb_consts.vh ***
// Purpose: shared constants of the serial break and LIN header block
// Assumes: one clock, 16 oversampling ticks per bit from a divider
// Notes: counts are in bit times unless named otherwise; LSB_RX_BRK_BITS is in oversampling ticks
`ifndef LSB_CONSTS_VH
`define LSB_CONSTS_VH
`define LSB_OS_PER_BIT      5'd16
`define LSB_OS_MID          4'h8
`define LSB_BRK_BITS_8      4'ha
`define LSB_BRK_BITS_9      4'hb
`define LSB_BRK_BITS_LIN    4'hd
`define LSB_IDLE_BITS_8     4'ha
`define LSB_IDLE_BITS_9     4'hb
`define LSB_DATA_BITS_8     4'ha
`define LSB_DATA_BITS_9     4'hb
`define LSB_HDR_MAX_BITS    6'h39
`define LSB_RX_BRK_BITS     8'hb0
`define LSB_TX_IDLE         2'h0
`define LSB_TX_IDLECHR      2'h1
`define LSB_TX_BREAK        2'h2
`define LSB_TX_DATA         2'h3
`define LSB_HDR_NONE        2'h0
`define LSB_HDR_BREAK       2'h1
`define LSB_HDR_SYNC        2'h2
`define LSB_HDR_IDENT       2'h3
`endif

// *** tb/lsb_checker_assertions.sv ***
// Purpose: port checks for the break and header block
// Assumes: baud_div_i of 1, so one bit is 16 clocks
// Notes: bound to lsb_core at the foot
module lsb_checker (
  input wire sys_clk_i,
  input wire reset_i,
  input wire transmitter_enable_bit_i,
  input wire send_break_bit_i,
  input wire word_len_bit_i,
  input wire lin_enable_bit_i,
  input wire data_rd_i,
  input wire tx_pin_o,
  input wire tx_ready_o,
  input wire lin_master_o,
  input wire mute_o,
  input wire receive_full_flag_o,
  input wire header_detected_flag_o,
  input wire header_error_flag_o,
  input wire irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] run_q;
  // clocks the serial output has been low
  always @(posedge sys_clk_i) begin
    if (reset_i || tx_pin_o) run_q <= 12'h000;
    else run_q <= run_q + 12'h001;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // break asked of an idle, enabled transmitter
  sequence s_brk_req;
    $rose(send_break_bit_i) && transmitter_enable_bit_i && $past(tx_ready_o);
  endsequence
  brk_start_a: assert property (s_brk_req |-> ##[1:3] !tx_pin_o)
    else $error("break did not start");
  brk_len_a: assert property ($rose(tx_pin_o) && run_q >= 12'ha0 |->
    run_q % 12'ha0 == 0 || run_q % 12'hb0 == 0 || run_q % 12'hd0 == 0)
    else $error("break length off");
  lin_mode_a: assert property (lin_master_o == (lin_enable_bit_i && !word_len_bit_i))
    else $error("lin master wrong");
  irq_flags_a: assert property (irq_o ==
    (receive_full_flag_o || header_detected_flag_o || header_error_flag_o))
    else $error("irq not flags");
  err_alone_a: assert property ($rose(header_error_flag_o) |-> !header_detected_flag_o)
    else $error("detect set on timeout");
  mute_keep_a: assert property ($rose(header_error_flag_o) |-> mute_o == $past(mute_o))
    else $error("mute changed on timeout");
  mute_rx_a: assert property ($rose(receive_full_flag_o) && $past(mute_o) |->
    $rose(header_detected_flag_o))
    else $error("muted byte taken");
  err_clear_a: assert property ($fell(header_error_flag_o) |-> $past(data_rd_i))
    else $error("error cleared early");
endmodule
bind lsb_core lsb_checker lsb_checker_i (.sys_clk_i, .reset_i, .transmitter_enable_bit_i,
  .send_break_bit_i, .word_len_bit_i, .lin_enable_bit_i, .data_rd_i, .tx_pin_o, .tx_ready_o,
  .lin_master_o, .mute_o, .receive_full_flag_o, .header_detected_flag_o,
  .header_error_flag_o, .irq_o);

// *** tb/lsb_peer.sv ***
// Purpose: far-side bus node driving the receive line
// Assumes: one bit is 16 clocks of clk_i
// Notes: line rests high like a pulled-up bus
module lsb_peer (
  input  wire  clk_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // released line rests recessive
  initial line_o = 1'b1;
  // hold a level for n clocks
  task automatic hold(input logic v, input int n);
    line_o = v;
    repeat (n) @(negedge clk_i);
  endtask
  // start, eight bits lsb first, stop
  task automatic send(input logic [7:0] b);
    hold(1'b0, 16);
    for (int i = 0; i < 8; i++) hold(b[i], 16);
    hold(1'b1, 16);
  endtask
  // break, delimiter, sync, gap, identifier
  task automatic hdr(input int gap, input logic [7:0] id);
    hold(1'b0, 208);
    hold(1'b1, 16);
    send(8'h55);
    hold(1'b1, gap);
    send(id);
  endtask
endmodule

// *** tb/lin_serial_break_header_bench.sv ***
// Purpose: self-checking bench for the break and header block
// Assumes: baud_div_i of 1, one bit is 16 clocks
// Notes: inputs change on the falling edge
module lin_serial_break_header_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic      sys_clk_i, reset_i, tx_en, brk_bit, m, lin, slv, mset, srd, drd;
  wire       rx, tx, rdy, lm, mute, rx_full, hdr_found, hdr_err, irq;
  wire [7:0] dat;
  int        miscompares, checked, w;
  // 40 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  lsb_peer lsb_peer_i (.clk_i(sys_clk_i), .line_o(rx));
  lsb_core lsb_core_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .baud_div_i(16'h0001), .transmitter_enable_bit_i(tx_en), .send_break_bit_i(brk_bit),
    .word_len_bit_i(m), .lin_enable_bit_i(lin), .lin_slave_bit_i(slv), .tx_data_i(8'h00),
    .tx_load_i(1'b0), .mute_set_i(mset), .status_rd_i(srd), .data_rd_i(drd), .rx_pin_i(rx),
    .tx_pin_o(tx), .tx_ready_o(rdy), .lin_master_o(lm), .mute_o(mute), .receive_full_flag_o(rx_full),
    .header_detected_flag_o(hdr_found), .header_error_flag_o(hdr_err), .serial_data_register_o(dat),
    .irq_o(irq));
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task close_out;
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // wait for a low run, clear break at clock rel, measure it
  task automatic low_run(input int exp, input int rel);
    int n;
    n = 0;
    w = 0;
    while (tx !== 1'b0 && w < 400) begin
      w++;
      cyc(1);
    end
    while (tx === 1'b0 && n < 1000) begin
      n++;
      if (n == rel) brk_bit = 1'b0;
      cyc(1);
    end
    chk(n == exp, "break length");
  endtask
  task automatic brk(input logic mv, input logic lv, input int exp);
    m = mv;
    lin = lv;
    cyc(20);
    brk_bit = 1'b1;
    cyc(1);
    brk_bit = 1'b0;
    low_run(exp, 0);
    chk(lm === (lv & ~mv), "lin master");
    chk(rdy === 1'b1, "not ready after one break");
  endtask
  task automatic idle_brk;
    m = 1'b0;
    lin = 1'b0;
    tx_en = 1'b0;
    cyc(1);
    tx_en = 1'b1;
    cyc(1);
    brk_bit = 1'b1;
    cyc(1);
    brk_bit = 1'b0;
    low_run(160, 0);
    chk(w >= 155 && w <= 164, "no idle first");
  endtask
  task automatic slave_timeout;
    lin = 1'b1;
    slv = 1'b1;
    mset = 1'b1;
    cyc(1);
    mset = 1'b0;
    lsb_peer_i.hdr(382, 8'h3c);
    cyc(40);
    chk(hdr_err === 1'b1 && irq === 1'b1, "no timeout");
    chk(hdr_found === 1'b0 && mute === 1'b1 && rx_full === 1'b0, "woke");
    srd = 1'b1;
    cyc(1);
    srd = 1'b0;
    cyc(2);
    chk(hdr_err === 1'b1, "early clear");
    drd = 1'b1;
    cyc(1);
    drd = 1'b0;
    cyc(1);
    chk(hdr_err === 1'b0 && irq === 1'b0, "not cleared");
  endtask
  task automatic slave_header;
    lsb_peer_i.send(8'ha5);
    cyc(4);
    chk(rx_full === 1'b0 && mute === 1'b1, "muted byte");
    lsb_peer_i.hdr(16, 8'h12);
    cyc(4);
    chk(hdr_found === 1'b1 && rx_full === 1'b1 && mute === 1'b0, "no wake");
    chk(dat === 8'h12, "ident");
  endtask
  // bounded run time
  initial begin
    #500us;
    miscompares++;
    close_out;
  end
  // main sequence
  initial begin
    {reset_i, tx_en, brk_bit, m, lin, slv, mset, srd, drd} = 9'h100;
    miscompares = 0;
    checked = 0;
    cyc(10);
    reset_i = 1'b0;
    cyc(1);
    tx_en = 1'b1;
    brk(1'b0, 1'b0, 160);
    brk(1'b1, 1'b0, 176);
    brk(1'b0, 1'b1, 208);
    lin = 1'b0;
    cyc(20);
    brk_bit = 1'b1;
    low_run(320, 200);
    idle_brk;
    slave_timeout;
    slave_header;
    close_out;
  end
endmodule
